// >>> logic/tmr_pkg.sv
package tmr_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [2:0] OFF_CONTROL = 3'h0;
    localparam logic [2:0] OFF_PIN_CONTROL = 3'h1;
    localparam logic [2:0] OFF_MODE = 3'h2;
    localparam logic [2:0] OFF_PRESCALER = 3'h3;
    localparam logic [2:0] OFF_TIMER = 3'h4;

    // Control register fields
    localparam int START_COUNT_BIT = 0;
    localparam int FORCED_STOP_BIT = 1;
    localparam int LEVEL_STATUS_BIT = 2;
    // Pin control register fields
    localparam int EDGE_LEVEL_SELECT_BIT = 0;
    localparam int INPUT_PIN_SELECT_BIT = 1;
    localparam int OUTPUT_ENABLE_BIT = 2;
    localparam int FILTER_SELECT_LOW_BIT = 4;
    localparam int FILTER_SELECT_HIGH_BIT = 5;
    // Mode register fields
    localparam int MODE_LSB = 0;
    localparam int PULSE_START_LEVEL_BIT = 3;
    localparam int SOURCE_LSB = 4;

    localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] PRESCALER_RESET = 8'hFF;
    localparam logic [7:0] TIMER_RESET = 8'hFF;

    // Filter sampling divider limits: one sample every limit+1 system clocks
    localparam logic [4:0] FILTER_DIV_FAST = 5'h00;
    localparam logic [4:0] FILTER_DIV_MID = 5'h07;
    localparam logic [4:0] FILTER_DIV_SLOW = 5'h1F;
    localparam logic [2:0] CLK_DIV2_MASK = 3'h1;
    localparam logic [2:0] CLK_DIV8_MASK = 3'h7;

    typedef enum logic [1:0] {
        MODE_EVENT = 2'b01,
        MODE_WIDTH = 2'b10
    } mode_t;

    typedef enum logic [2:0] {
        SRC_DIV1 = 3'h0,
        SRC_DIV2 = 3'h1,
        SRC_DIV8 = 3'h2,
        SRC_OSC = 3'h3,
        SRC_SUB32 = 3'h4
    } src_t;

    typedef struct packed {
        logic [1:0] filter_sel;
        logic output_enable;
        logic input_pin_select;
        logic edge_level_select;
    } pin_ctl_t;

    typedef struct packed {
        src_t source;
        logic pulse_start_level;
        mode_t mode;
    } mode_ctl_t;
endpackage

// >>> logic/input_conditioner.sv
`timescale 1ns/1ns
module input_conditioner (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic pin_i,
    input wire logic [1:0] filter_sel_i,
    output logic level_o
);
    logic sync1_reg;
    logic sync2_reg;
    logic [4:0] div_reg;
    logic [4:0] div_lim;
    logic [2:0] samp_reg;
    logic samp_tick;

    always_comb begin
        case (filter_sel_i)
            2'h1: div_lim = tmr_pkg::FILTER_DIV_FAST;
            2'h2: div_lim = tmr_pkg::FILTER_DIV_MID;
            default: div_lim = tmr_pkg::FILTER_DIV_SLOW;
        endcase
    end
    assign samp_tick = (div_reg >= div_lim);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (ce_i) begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            div_reg <= 5'h00;
            samp_reg <= 3'h0;
        end else if (ce_i) begin
            div_reg <= samp_tick ? 5'h00 : div_reg + 5'h01;
            if (samp_tick) begin
                samp_reg <= {samp_reg[1:0], sync2_reg};
            end
        end
    end

    // Unless select is 0 (bypass), a level passes only after three equal samples
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            level_o <= 1'b0;
        end else if (ce_i) begin
            if (filter_sel_i == 2'h0) begin
                level_o <= sync2_reg;
            end else if (samp_reg == 3'h7) begin
                level_o <= 1'b1;
            end else if (samp_reg == 3'h0) begin
                level_o <= 1'b0;
            end
        end
    end
endmodule

// >>> logic/source_select.sv
`timescale 1ns/1ns
module source_select (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire tmr_pkg::src_t source_i,
    input wire logic onchip_osc_clk_i,
    input wire logic subclock_div32_i,
    output logic tick_o
);
    logic [2:0] div_reg;
    logic osc_d_reg;
    logic sub_d_reg;
    logic tick_next;

    always_comb begin
        case (source_i)
            tmr_pkg::SRC_DIV1: tick_next = 1'b1;
            tmr_pkg::SRC_DIV2:
                tick_next = (div_reg & tmr_pkg::CLK_DIV2_MASK) == 3'h0;
            tmr_pkg::SRC_DIV8:
                tick_next = (div_reg & tmr_pkg::CLK_DIV8_MASK) == 3'h0;
            tmr_pkg::SRC_OSC: tick_next = onchip_osc_clk_i && !osc_d_reg;
            tmr_pkg::SRC_SUB32: tick_next = subclock_div32_i && !sub_d_reg;
            default: tick_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            div_reg <= 3'h0;
            osc_d_reg <= 1'b0;
            sub_d_reg <= 1'b0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            div_reg <= div_reg + 3'h1;
            osc_d_reg <= onchip_osc_clk_i;
            sub_d_reg <= subclock_div32_i;
            tick_o <= tick_next;
        end
    end
endmodule

// >>> logic/event_count_pulse_width_timer.sv
// What this block does
// - Event mode counts edges of the input pin
// - Decrement; reload on underflow and continue
// - Ratio 1/(n+1)(m+1), prescaler clocks timer
// - Writing start bit 1 starts counting
// - Writing start bit 0 halts counting
// - Writing forced stop bit 1 stops counting
// - Timer underflow raises interrupt in both modes
// - Reads return current prescaler and timer counts
// - Stopped write loads reload and counter
// - Running write loads reload, counter later
// - Edge select picks active edge in event mode
// - Pin select chooses one of two pins
// - Output pin toggles on underflow in event mode when enabled
// - Mode write sets output pin start level
// - Filter field bypasses or picks sampling rate
// - Width mode uses one of five clocks
// - Width mode counts only at selected level
// - Edge select picks measured level in width mode
// - End of measured level raises interrupt
// - Input pin also serves as external interrupt
// - Prescaler takes written value on count source
// - Timer takes written value on prescaler underflow
`timescale 1ns/1ns
module event_count_pulse_width_timer (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    input wire logic alt_input_pin_a_i,
    input wire logic alt_input_pin_b_i,
    input wire logic onchip_osc_clk_i,
    input wire logic subclock_div32_i,
    output logic secondary_output_pin_o,
    output logic external_interrupt_one_o,
    output logic timer_irq_o
);
    logic run_reg;
    tmr_pkg::pin_ctl_t pin_ctl_reg;
    tmr_pkg::mode_ctl_t mode_reg;
    logic [7:0] pre_reload_reg;
    logic [7:0] pre_cnt_reg;
    logic pre_pend_reg;
    logic [7:0] tmr_reload_reg;
    logic [7:0] tmr_cnt_reg;
    logic tmr_pend_reg;
    logic level_d_reg;
    logic timer_io_pin;
    logic level;
    logic src_tick;
    logic is_event;
    logic is_width;
    logic active_edge;
    logic level_ok;
    logic width_end;
    logic tick;
    logic pre_uf;
    logic tmr_uf;
    logic wr_ctrl;
    logic wr_pin;
    logic wr_mode;
    logic wr_pre;
    logic wr_tmr;

    assign wr_ctrl = we_i && addr_i == tmr_pkg::OFF_CONTROL;
    assign wr_pin = we_i && addr_i == tmr_pkg::OFF_PIN_CONTROL;
    assign wr_mode = we_i && addr_i == tmr_pkg::OFF_MODE;
    assign wr_pre = we_i && addr_i == tmr_pkg::OFF_PRESCALER;
    assign wr_tmr = we_i && addr_i == tmr_pkg::OFF_TIMER;

    // Pin choice
    assign timer_io_pin = pin_ctl_reg.input_pin_select ?
        alt_input_pin_b_i : alt_input_pin_a_i;

    input_conditioner u_cond (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .pin_i(timer_io_pin),
        .filter_sel_i(pin_ctl_reg.filter_sel),
        .level_o(level)
    );

    source_select u_src (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .source_i(mode_reg.source),
        .onchip_osc_clk_i(onchip_osc_clk_i),
        .subclock_div32_i(subclock_div32_i),
        .tick_o(src_tick)
    );

    assign is_event = mode_reg.mode == tmr_pkg::MODE_EVENT;
    assign is_width = mode_reg.mode == tmr_pkg::MODE_WIDTH;

    // Rising edge when select is 0, falling when 1
    assign active_edge = pin_ctl_reg.edge_level_select ?
        (level_d_reg && !level) : (level && !level_d_reg);
    // High period when select is 0, low when 1
    assign level_ok = level != pin_ctl_reg.edge_level_select;
    // Leaving the measured level ends the period
    assign width_end = is_width && run_reg &&
        (level_d_reg != pin_ctl_reg.edge_level_select) && !level_ok;

    assign tick = run_reg && ce_i &&
        ((is_event && active_edge) || (is_width && src_tick && level_ok));
    // A pending reload uses the tick instead of counting
    assign pre_uf = tick && !pre_pend_reg && pre_cnt_reg == 8'h00;
    assign tmr_uf = pre_uf && !tmr_pend_reg && tmr_cnt_reg == 8'h00;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            level_d_reg <= 1'b0;
        end else if (ce_i) begin
            level_d_reg <= level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            run_reg <= 1'b0;
        end else if (ce_i && wr_ctrl) begin
            // Forced stop overrides a start in the same write
            run_reg <= wdata_i[tmr_pkg::START_COUNT_BIT] &&
                !wdata_i[tmr_pkg::FORCED_STOP_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pin_ctl_reg <= tmr_pkg::pin_ctl_t'(tmr_pkg::PIN_CONTROL_RESET);
        end else if (ce_i && wr_pin) begin
            pin_ctl_reg.edge_level_select <=
                wdata_i[tmr_pkg::EDGE_LEVEL_SELECT_BIT];
            pin_ctl_reg.input_pin_select <=
                wdata_i[tmr_pkg::INPUT_PIN_SELECT_BIT];
            pin_ctl_reg.output_enable <= wdata_i[tmr_pkg::OUTPUT_ENABLE_BIT];
            pin_ctl_reg.filter_sel <= wdata_i[tmr_pkg::FILTER_SELECT_HIGH_BIT:
                tmr_pkg::FILTER_SELECT_LOW_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mode_reg <= tmr_pkg::mode_ctl_t'(tmr_pkg::MODE_RESET);
        end else if (ce_i && wr_mode) begin
            // Unknown mode codes fall back to event counting
            if (wdata_i[tmr_pkg::MODE_LSB +: 2] == 2'b10) begin
                mode_reg.mode <= tmr_pkg::MODE_WIDTH;
            end else begin
                mode_reg.mode <= tmr_pkg::MODE_EVENT;
            end
            mode_reg.pulse_start_level <=
                wdata_i[tmr_pkg::PULSE_START_LEVEL_BIT];
            mode_reg.source <=
                tmr_pkg::src_t'(wdata_i[tmr_pkg::SOURCE_LSB +: 3]);
        end
    end

    // Prescaler stage
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pre_reload_reg <= tmr_pkg::PRESCALER_RESET;
            pre_cnt_reg <= tmr_pkg::PRESCALER_RESET;
            pre_pend_reg <= 1'b0;
        end else if (ce_i) begin
            if (wr_pre) begin
                pre_reload_reg <= wdata_i;
            end
            if (wr_pre && !run_reg) begin
                pre_cnt_reg <= wdata_i;
                pre_pend_reg <= 1'b0;
            end else if (wr_pre) begin
                // A tick in the write cycle still counts the old value
                pre_pend_reg <= 1'b1;
                if (tick && (pre_pend_reg || pre_cnt_reg == 8'h00)) begin
                    pre_cnt_reg <= pre_reload_reg;
                end else if (tick) begin
                    pre_cnt_reg <= pre_cnt_reg - 8'h01;
                end
            end else if (tick) begin
                pre_pend_reg <= 1'b0;
                if (pre_pend_reg || pre_cnt_reg == 8'h00) begin
                    pre_cnt_reg <= pre_reload_reg;
                end else begin
                    pre_cnt_reg <= pre_cnt_reg - 8'h01;
                end
            end
        end
    end

    // Timer stage, clocked by prescaler underflow
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tmr_reload_reg <= tmr_pkg::TIMER_RESET;
            tmr_cnt_reg <= tmr_pkg::TIMER_RESET;
            tmr_pend_reg <= 1'b0;
        end else if (ce_i) begin
            if (wr_tmr) begin
                tmr_reload_reg <= wdata_i;
            end
            if (wr_tmr && !run_reg) begin
                tmr_cnt_reg <= wdata_i;
                tmr_pend_reg <= 1'b0;
            end else if (wr_tmr) begin
                tmr_pend_reg <= 1'b1;
                if (pre_uf && (tmr_pend_reg || tmr_cnt_reg == 8'h00)) begin
                    tmr_cnt_reg <= tmr_reload_reg;
                end else if (pre_uf) begin
                    tmr_cnt_reg <= tmr_cnt_reg - 8'h01;
                end
            end else if (pre_uf) begin
                tmr_pend_reg <= 1'b0;
                if (tmr_pend_reg || tmr_cnt_reg == 8'h00) begin
                    tmr_cnt_reg <= tmr_reload_reg;
                end else begin
                    tmr_cnt_reg <= tmr_cnt_reg - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            timer_irq_o <= 1'b0;
        end else if (ce_i) begin
            timer_irq_o <= tmr_uf || width_end;
        end
    end

    // Pin level stays visible as an interrupt input
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            external_interrupt_one_o <= 1'b0;
        end else if (ce_i) begin
            external_interrupt_one_o <= level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            secondary_output_pin_o <= 1'b0;
        end else if (ce_i) begin
            if (wr_mode) begin
                secondary_output_pin_o <=
                    wdata_i[tmr_pkg::PULSE_START_LEVEL_BIT];
            end else if (tmr_uf && is_event && pin_ctl_reg.output_enable) begin
                secondary_output_pin_o <= !secondary_output_pin_o;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= 8'h00;
            if (re_i) begin
                case (addr_i)
                    tmr_pkg::OFF_CONTROL: begin
                        rdata_o[tmr_pkg::START_COUNT_BIT] <= run_reg;
                        rdata_o[tmr_pkg::LEVEL_STATUS_BIT] <= level;
                    end
                    tmr_pkg::OFF_PIN_CONTROL: begin
                        rdata_o[tmr_pkg::EDGE_LEVEL_SELECT_BIT] <=
                            pin_ctl_reg.edge_level_select;
                        rdata_o[tmr_pkg::INPUT_PIN_SELECT_BIT] <=
                            pin_ctl_reg.input_pin_select;
                        rdata_o[tmr_pkg::OUTPUT_ENABLE_BIT] <=
                            pin_ctl_reg.output_enable;
                        rdata_o[tmr_pkg::FILTER_SELECT_HIGH_BIT:
                            tmr_pkg::FILTER_SELECT_LOW_BIT] <=
                            pin_ctl_reg.filter_sel;
                    end
                    tmr_pkg::OFF_MODE: begin
                        rdata_o[tmr_pkg::MODE_LSB +: 2] <= mode_reg.mode;
                        rdata_o[tmr_pkg::PULSE_START_LEVEL_BIT] <=
                            mode_reg.pulse_start_level;
                        rdata_o[tmr_pkg::SOURCE_LSB +: 3] <= mode_reg.source;
                    end
                    tmr_pkg::OFF_PRESCALER: rdata_o <= pre_cnt_reg;
                    tmr_pkg::OFF_TIMER: rdata_o <= tmr_cnt_reg;
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_start;
        ce_i && wr_ctrl && wdata_i[tmr_pkg::START_COUNT_BIT] &&
            !wdata_i[tmr_pkg::FORCED_STOP_BIT] |=> run_reg;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_halt;
        ce_i && wr_ctrl && !wdata_i[tmr_pkg::START_COUNT_BIT] |=> !run_reg;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not taken");

    property p_forced;
        ce_i && wr_ctrl && wdata_i[tmr_pkg::FORCED_STOP_BIT] |=> !run_reg;
    endproperty
    a_forced: assert property (p_forced) else $error("stop failed");

    property p_stopped_write;
        ce_i && wr_pre && !run_reg |=>
            pre_cnt_reg == $past(wdata_i) && pre_reload_reg == $past(wdata_i);
    endproperty
    a_stopped_write: assert property (p_stopped_write)
        else $error("stopped write lost");

    property p_reload;
        ce_i && tmr_uf && !we_i |=> tmr_cnt_reg == tmr_reload_reg &&
            pre_cnt_reg == pre_reload_reg;
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");

    property p_irq;
        ce_i && tmr_uf |=> timer_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_toggle;
        ce_i && tmr_uf && is_event && pin_ctl_reg.output_enable && !wr_mode
            |=> secondary_output_pin_o != $past(secondary_output_pin_o);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");

    property p_read;
        ce_i && re_i && addr_i == tmr_pkg::OFF_TIMER |=>
            rdata_o == $past(tmr_cnt_reg);
    endproperty
    a_read: assert property (p_read) else $error("bad timer read");

    property p_hold;
        ce_i && is_width && !level_ok && !we_i |=>
            pre_cnt_reg == $past(pre_cnt_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved");

    c_event_uf: cover property (is_event && tmr_uf);
    c_width_end: cover property (width_end);
    c_deferred: cover property (pre_pend_reg ##[1:50] tick);
endmodule

// >>> test/sig_source.sv
`timescale 1ns/1ns
module sig_source (
    input wire logic clk_i,
    input wire logic level_i,
    input wire logic sel_b_i,
    output logic pin_a_o,
    output logic pin_b_o
);
    // The pin not in use toggles, so a wrong pin choice shows up as counts
    initial begin
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
    end
    always @(posedge clk_i) begin
        pin_a_o <= sel_b_i ? ~pin_a_o : level_i;
        pin_b_o <= sel_b_i ? level_i : ~pin_b_o;
    end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic level = 1'b0;
    logic sel_b = 1'b0;
    logic osc = 1'b0;
    logic sub = 1'b0;
    logic pin_a;
    logic pin_b;
    logic [7:0] rdata_o;
    logic sec_out;
    logic ext_irq;
    logic irq;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int irq_cnt = 0;
    int irq_base = 0;
    int hi[5] = '{20, 20, 24, 20, 24};
    int tk[5] = '{20, 10, 3, 5, 3};

    event_count_pulse_width_timer DUT (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(1'b1),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .we_i(we_i),
        .re_i(re_i),
        .rdata_o(rdata_o),
        .alt_input_pin_a_i(pin_a),
        .alt_input_pin_b_i(pin_b),
        .onchip_osc_clk_i(osc),
        .subclock_div32_i(sub),
        .secondary_output_pin_o(sec_out),
        .external_interrupt_one_o(ext_irq),
        .timer_irq_o(irq)
    );

    sig_source SRC (
        .clk_i(clk_i),
        .level_i(level),
        .sel_b_i(sel_b),
        .pin_a_o(pin_a),
        .pin_b_o(pin_b)
    );

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Oscillator period 4 clocks, sub-clock period 8 clocks
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        osc <= cyc[1];
        sub <= cyc[2];
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
        if (cyc == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask

    // Level stands for exactly n clocks before the next call moves it
    task automatic hold(input logic v, input int n);
        @(posedge clk_i);
        level <= v;
        repeat (n - 1) @(posedge clk_i);
    endtask

    // Levels held well past the synchroniser delay
    task automatic pulses(input int n);
        repeat (n) begin
            hold(1'b1, 8);
            hold(1'b0, 8);
        end
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        rc(tmr_pkg::OFF_PIN_CONTROL, 8'h00);
        rc(tmr_pkg::OFF_MODE, 8'h01);
        rc(tmr_pkg::OFF_PRESCALER, 8'hFF);
        rc(tmr_pkg::OFF_TIMER, 8'hFF);
        wr(3'h5, 8'h3C);
        rc(3'h5, 8'h00);
        wr(tmr_pkg::OFF_PIN_CONTROL, 8'h04);
        wr(tmr_pkg::OFF_MODE, 8'h09);
        repeat (2) @(posedge clk_i);
        chk({7'h00, sec_out}, 8'h01);
        wr(tmr_pkg::OFF_MODE, 8'h01);
        repeat (2) @(posedge clk_i);
        chk({7'h00, sec_out}, 8'h00);
        wr(tmr_pkg::OFF_PRESCALER, 8'h02);
        wr(tmr_pkg::OFF_TIMER, 8'h01);
        rc(tmr_pkg::OFF_PRESCALER, 8'h02);
        rc(tmr_pkg::OFF_TIMER, 8'h01);
        wr(tmr_pkg::OFF_CONTROL, 8'h01);
        rc(tmr_pkg::OFF_CONTROL, 8'h01);
        pulses(4);
        rc(tmr_pkg::OFF_PRESCALER, 8'h01);
        rc(tmr_pkg::OFF_TIMER, 8'h00);
        chk(8'(irq_cnt), 8'h00);
        pulses(2);
        chk(8'(irq_cnt), 8'h01);
        chk({7'h00, sec_out}, 8'h01);
        rc(tmr_pkg::OFF_PRESCALER, 8'h02);
        rc(tmr_pkg::OFF_TIMER, 8'h01);
        wr(tmr_pkg::OFF_PRESCALER, 8'h05);
        rc(tmr_pkg::OFF_PRESCALER, 8'h02);
        pulses(1);
        rc(tmr_pkg::OFF_PRESCALER, 8'h05);
        wr(tmr_pkg::OFF_TIMER, 8'h03);
        rc(tmr_pkg::OFF_TIMER, 8'h01);
        pulses(6);
        rc(tmr_pkg::OFF_TIMER, 8'h03);
        chk(8'(irq_cnt), 8'h01);
        wr(tmr_pkg::OFF_PIN_CONTROL, 8'h05);
        hold(1'b1, 10);
        rc(tmr_pkg::OFF_PRESCALER, 8'h05);
        hold(1'b0, 10);
        rc(tmr_pkg::OFF_PRESCALER, 8'h04);
        wr(tmr_pkg::OFF_CONTROL, 8'h00);
        pulses(1);
        rc(tmr_pkg::OFF_PRESCALER, 8'h04);
        rc(tmr_pkg::OFF_CONTROL, 8'h00);
        wr(tmr_pkg::OFF_CONTROL, 8'h01);
        wr(tmr_pkg::OFF_CONTROL, 8'h03);
        pulses(1);
        rc(tmr_pkg::OFF_PRESCALER, 8'h04);
        rc(tmr_pkg::OFF_CONTROL, 8'h00);
        sel_b <= 1'b1;
        wr(tmr_pkg::OFF_PIN_CONTROL, 8'h06);
        hold(1'b0, 8);
        wr(tmr_pkg::OFF_CONTROL, 8'h01);
        pulses(2);
        rc(tmr_pkg::OFF_PRESCALER, 8'h02);
        wr(tmr_pkg::OFF_CONTROL, 8'h00);
        sel_b <= 1'b0;
        wr(tmr_pkg::OFF_PRESCALER, 8'h08);
        // Filter rates: a two-clock glitch is dropped, a long pulse counts
        for (int f = 1; f < 4; f++) begin
            wr(tmr_pkg::OFF_PIN_CONTROL, 8'(f << 4));
            hold(1'b0, 8);
            wr(tmr_pkg::OFF_CONTROL, 8'h01);
            hold(1'b1, 2);
            hold(1'b0, 160);
            rc(tmr_pkg::OFF_PRESCALER, 8'(9 - f));
            hold(1'b1, 160);
            chk({7'h00, ext_irq}, 8'h01);
            rc(tmr_pkg::OFF_CONTROL, 8'h05);
            hold(1'b0, 160);
            rc(tmr_pkg::OFF_PRESCALER, 8'(8 - f));
            wr(tmr_pkg::OFF_CONTROL, 8'h00);
        end
        wr(tmr_pkg::OFF_PIN_CONTROL, 8'h00);
        for (int s = 0; s < 5; s++) begin
            wr(tmr_pkg::OFF_MODE, 8'(s * 16 + 2));
            wr(tmr_pkg::OFF_PRESCALER, 8'hFF);
            wr(tmr_pkg::OFF_CONTROL, 8'h01);
            irq_base = irq_cnt;
            hold(1'b1, hi[s]);
            hold(1'b0, 12);
            wr(tmr_pkg::OFF_CONTROL, 8'h00);
            rc(tmr_pkg::OFF_PRESCALER, 8'(255 - tk[s]));
            chk(8'(irq_cnt - irq_base), 8'h01);
        end
        wr(tmr_pkg::OFF_PIN_CONTROL, 8'h01);
        hold(1'b1, 10);
        wr(tmr_pkg::OFF_MODE, 8'h02);
        wr(tmr_pkg::OFF_PRESCALER, 8'hFF);
        wr(tmr_pkg::OFF_CONTROL, 8'h01);
        hold(1'b0, 16);
        hold(1'b1, 12);
        wr(tmr_pkg::OFF_CONTROL, 8'h00);
        rc(tmr_pkg::OFF_PRESCALER, 8'hEF);
        tally_and_finish();
    end
endmodule
